// ---- core/sws_seq.sv ----
// stimulus waveform sequencer: register port, tick divider, protocol engine, dac code
module sws_seq
	import sws_pkg::*;
#(
	parameter int TICK0 = TICK0_CYC,
	parameter int TICK1 = TICK1_CYC,
	parameter int TICK2 = TICK2_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic      [15:0] dac_code_o
);

	sws_cfg_t           cfg_r;
	sws_state_t         state_r;
	logic [19:0]        pre_r;
	logic               tick;
	logic [15:0]        tcnt_r;
	logic [15:0]        pcnt_r;
	logic [15:0]        rcnt_r;
	logic signed [15:0] step_lvl_r;
	logic signed [15:0] inc_r;
	logic signed [15:0] dac_nxt;
	logic signed [15:0] dac_r;
	logic               rec_d_r;
	logic               start;
	logic               ph_end;
	logic [19:0]        tick_len;
	logic [31:0]        rdata_r;

	// phase of len ticks ends at its last tick
	function automatic logic fin(input logic [15:0] t, input logic [15:0] n);
		fin = ({1'b0, t} + 17'h00001) >= {1'b0, n};
	endfunction

	// linear point a + (b - a) * t / n, reaches b at t == n
	function automatic logic signed [15:0] lerp(input logic signed [15:0] a, input logic signed [15:0] b,
		input logic [15:0] t, input logic [15:0] n);
		logic signed [34:0] d;
		logic signed [34:0] q;
		d = 35'(b) - 35'(a);
		if (n == 16'h0000) begin
			q = d;
		end else begin
			q = (d * $signed({19'h00000, t})) / $signed({19'h00000, n});
		end
		lerp = 16'(q + 35'(a));
	endfunction

	// register writes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= CFG_RESET;
		end else if (wr_i) begin
			case (addr_i)
				ADDR_CTRL: begin
					cfg_r.rec  <= wdata_i[CTRL_REC_BIT];
					cfg_r.mode <= wdata_i[CTRL_MODE_LO +: 3];
					cfg_r.res  <= wdata_i[CTRL_RES_LO +: 2];
				end
				ADDR_DELAY:  cfg_r.delay   <= wdata_i[15:0];
				ADDR_AMP:    cfg_r.amp     <= wdata_i[15:0];
				ADDR_DAMP:   cfg_r.damp    <= wdata_i[15:0];
				ADDR_HOLD:   cfg_r.hold    <= wdata_i[15:0];
				ADDR_STOP:   cfg_r.stop    <= wdata_i[15:0];
				ADDR_COUNT:  cfg_r.count   <= wdata_i[15:0];
				ADDR_WIDTH:  cfg_r.width   <= wdata_i[15:0];
				ADDR_OFF:    cfg_r.off     <= wdata_i[15:0];
				ADDR_REPEAT: cfg_r.repeats <= wdata_i[15:0];
				ADDR_GAP:    cfg_r.gap     <= wdata_i[15:0];
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe, zero when unmapped
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 32'h00000000;
		end else if (rd_i) begin
			case (addr_i)
				ADDR_CTRL:   rdata_r <= {26'h0000000, cfg_r.res, cfg_r.mode, cfg_r.rec};
				ADDR_DELAY:  rdata_r <= {16'h0000, cfg_r.delay};
				ADDR_AMP:    rdata_r <= {16'h0000, cfg_r.amp};
				ADDR_DAMP:   rdata_r <= {16'h0000, cfg_r.damp};
				ADDR_HOLD:   rdata_r <= {16'h0000, cfg_r.hold};
				ADDR_STOP:   rdata_r <= {16'h0000, cfg_r.stop};
				ADDR_COUNT:  rdata_r <= {16'h0000, cfg_r.count};
				ADDR_WIDTH:  rdata_r <= {16'h0000, cfg_r.width};
				ADDR_OFF:    rdata_r <= {16'h0000, cfg_r.off};
				ADDR_REPEAT: rdata_r <= {16'h0000, cfg_r.repeats};
				ADDR_GAP:    rdata_r <= {16'h0000, cfg_r.gap};
				ADDR_STATUS: rdata_r <= {pcnt_r, 13'h0000, 3'(state_r)};
				default:     rdata_r <= 32'h00000000;
			endcase
		end else begin
			rdata_r <= 32'h00000000;
		end
	end
	assign rdata_o = rdata_r;

	// recording start edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rec_d_r <= 1'b0;
		end else begin
			rec_d_r <= cfg_r.rec;
		end
	end
	assign start = cfg_r.rec && !rec_d_r;

	// tick divider, restarted at recording start
	always_comb begin
		case (cfg_r.res)
			2'h0:    tick_len = 20'(TICK0);
			2'h1:    tick_len = 20'(TICK1);
			default: tick_len = 20'(TICK2);
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pre_r <= 20'h00000;
		end else if (start || tick) begin
			pre_r <= 20'h00000;
		end else begin
			pre_r <= pre_r + 20'h00001;
		end
	end
	assign tick = (pre_r + 20'h00001) >= tick_len;

	// current phase ends on this tick
	always_comb begin
		case (state_r)
			ST_DELAY: ph_end = fin(tcnt_r, cfg_r.delay);
			ST_ON:    ph_end = cfg_r.mode != MODE_CONST && fin(tcnt_r, cfg_r.width);
			ST_OFF:   ph_end = fin(tcnt_r, (cfg_r.mode == MODE_TRI) ? cfg_r.width : cfg_r.off);
			ST_GAP:   ph_end = fin(tcnt_r, cfg_r.gap);
			default:  ph_end = 1'b0;
		endcase
	end

	// protocol state machine
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			tcnt_r  <= 16'h0000;
			pcnt_r  <= 16'h0000;
			rcnt_r  <= 16'h0000;
		end else if (!cfg_r.rec) begin
			state_r <= ST_IDLE;
			tcnt_r  <= 16'h0000;
			pcnt_r  <= 16'h0000;
			rcnt_r  <= 16'h0000;
		end else if (start) begin
			state_r <= ST_DELAY;
			tcnt_r  <= 16'h0000;
			pcnt_r  <= 16'h0000;
			rcnt_r  <= 16'h0000;
		end else if (tick) begin
			tcnt_r <= ph_end ? 16'h0000 : tcnt_r + 16'h0001;
			if (ph_end) begin
				case (state_r)
					ST_DELAY: state_r <= ST_ON;
					ST_ON: begin
						pcnt_r <= pcnt_r + 16'h0001;
						case (cfg_r.mode)
							MODE_PULSE: begin
								if (cfg_r.count != 16'h0000 && pcnt_r + 16'h0001 == cfg_r.count) begin
									state_r <= ST_DONE;
								end else if (cfg_r.off != 16'h0000) begin
									state_r <= ST_OFF;
								end else begin
									state_r <= ST_ON;
								end
							end
							MODE_TRAIN, MODE_STEP: begin
								if (pcnt_r + 16'h0001 >= cfg_r.count) begin
									pcnt_r <= 16'h0000;
									rcnt_r <= rcnt_r + 16'h0001;
									state_r <= (rcnt_r + 16'h0001 >= cfg_r.repeats) ? ST_DONE : ST_GAP;
								end else if (cfg_r.off != 16'h0000) begin
									state_r <= ST_OFF;
								end else begin
									state_r <= ST_ON;
								end
							end
							MODE_TRI: state_r <= ST_OFF;
							default: begin
								rcnt_r  <= rcnt_r + 16'h0001;
								state_r <= (rcnt_r + 16'h0001 >= cfg_r.repeats) ? ST_DONE : ST_GAP;
							end
						endcase
					end
					ST_OFF: begin
						if (cfg_r.mode == MODE_TRI) begin
							rcnt_r  <= rcnt_r + 16'h0001;
							state_r <= (rcnt_r + 16'h0001 >= cfg_r.repeats) ? ST_DONE : ST_GAP;
						end else begin
							state_r <= ST_ON;
						end
					end
					ST_GAP:  state_r <= ST_ON;
					default: state_r <= state_r;
				endcase
			end
		end
	end

	// step level accumulator, restarted from start amplitude each pass
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			step_lvl_r <= 16'sh0000;
			inc_r      <= 16'sh0000;
		end else if (start) begin
			step_lvl_r <= cfg_r.amp;
			inc_r      <= (cfg_r.count == 16'h0000) ? 16'sh0000 :
				16'((35'(cfg_r.stop) - 35'(cfg_r.amp)) / $signed({19'h00000, cfg_r.count}));
		end else if (tick && ph_end && state_r == ST_ON && cfg_r.mode == MODE_STEP) begin
			step_lvl_r <= (pcnt_r + 16'h0001 >= cfg_r.count) ? cfg_r.amp : step_lvl_r + inc_r;
		end
	end

	// output level per state; start amplitude is the amp field in step and slope modes
	always_comb begin
		dac_nxt = cfg_r.hold;
		case (state_r)
			ST_DELAY: begin
				if (cfg_r.mode == MODE_RAMP || cfg_r.mode == MODE_TRI) begin
					dac_nxt = cfg_r.damp;
				end
			end
			ST_ON: begin
				case (cfg_r.mode)
					MODE_STEP:          dac_nxt = step_lvl_r;
					MODE_RAMP, MODE_TRI: dac_nxt = lerp(cfg_r.amp, cfg_r.stop, tcnt_r + 16'h0001, cfg_r.width);
					default:            dac_nxt = cfg_r.amp;
				endcase
			end
			ST_OFF: begin
				if (cfg_r.mode == MODE_TRI) begin
					dac_nxt = lerp(cfg_r.stop, cfg_r.amp, tcnt_r + 16'h0001, cfg_r.width);
				end
			end
			default: dac_nxt = cfg_r.hold;
		endcase
	end

	// registered dac code
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dac_r <= 16'sh0000;
		end else begin
			dac_r <= dac_nxt;
		end
	end
	assign dac_code_o = dac_r;

	// checks
	property p_abort;
		@(posedge clk_sys_i) disable iff (rst_i) $fell(cfg_r.rec) |=> state_r == ST_IDLE ##1 dac_r == cfg_r.hold;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not return to rest");

	property p_delay;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_DELAY && tick && tcnt_r + 16'h0001 < cfg_r.delay && cfg_r.rec) |=> state_r == ST_DELAY;
	endproperty
	a_delay: assert property (p_delay) else $error("delay ended early");

	property p_pulse_count;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_ON && cfg_r.mode == MODE_PULSE && cfg_r.count != 16'h0000) |-> pcnt_r < cfg_r.count;
	endproperty
	a_pulse_count: assert property (p_pulse_count) else $error("too many pulses");

	property p_pulse_amp;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_ON && cfg_r.mode == MODE_PULSE) |=> dac_r == $past(cfg_r.amp);
	endproperty
	a_pulse_amp: assert property (p_pulse_amp) else $error("pulse amplitude wrong");

	property p_const;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_ON && cfg_r.mode == MODE_CONST && cfg_r.rec) |=> state_r == ST_ON && dac_r == $past(cfg_r.amp);
	endproperty
	a_const: assert property (p_const) else $error("constant level lost");

	property p_delay_amp;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_DELAY && (cfg_r.mode == MODE_RAMP || cfg_r.mode == MODE_TRI)) |=> dac_r == $past(cfg_r.damp);
	endproperty
	a_delay_amp: assert property (p_delay_amp) else $error("delay amplitude wrong");

	property p_ramp_end;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_ON && cfg_r.mode == MODE_RAMP && tcnt_r + 16'h0001 == cfg_r.width) |=> dac_r == $past(cfg_r.stop);
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("ramp missed stop amplitude");

	property p_gap_hold;
		@(posedge clk_sys_i) disable iff (rst_i) (state_r == ST_GAP) |=> dac_r == $past(cfg_r.hold);
	endproperty
	a_gap_hold: assert property (p_gap_hold) else $error("gap not at holding level");

	property p_train_gap;
		@(posedge clk_sys_i) disable iff (rst_i)
			(tick && state_r == ST_ON && cfg_r.mode == MODE_TRAIN && ph_end && cfg_r.rec && !start
			&& pcnt_r + 16'h0001 >= cfg_r.count && rcnt_r + 16'h0001 < cfg_r.repeats) |=> state_r == ST_GAP;
	endproperty
	a_train_gap: assert property (p_train_gap) else $error("inter-train gap missing");

	property p_delay_hold;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_DELAY && cfg_r.mode != MODE_RAMP && cfg_r.mode != MODE_TRI)
			|=> dac_r == $past(cfg_r.hold);
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("output left rest during delay");

	property p_off_base;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_OFF && cfg_r.mode != MODE_TRI) |=> dac_r == $past(cfg_r.hold);
	endproperty
	a_off_base: assert property (p_off_base) else $error("off-time not at baseline");

	property p_tri_end;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_OFF && cfg_r.mode == MODE_TRI && tcnt_r + 16'h0001 == cfg_r.width)
			|=> dac_r == $past(cfg_r.amp);
	endproperty
	a_tri_end: assert property (p_tri_end) else $error("triangle did not return to start");

	property p_step_lvl;
		@(posedge clk_sys_i) disable iff (rst_i)
			(!start && tick && ph_end && state_r == ST_ON && cfg_r.mode == MODE_STEP
			&& pcnt_r + 16'h0001 < cfg_r.count) |=> step_lvl_r == $past(step_lvl_r) + $past(inc_r);
	endproperty
	a_step_lvl: assert property (p_step_lvl) else $error("step increment wrong");

	property p_done_hold;
		@(posedge clk_sys_i) disable iff (rst_i)
			(state_r == ST_DONE && cfg_r.rec) |=> state_r == ST_DONE && dac_r == $past(cfg_r.hold);
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("protocol resumed after done");

endmodule

// ---- include/sws_pkg.sv ----
// package: register map, modes, timing and config carrier of the stimulus sequencer
// Summary of operation
// - Pulse mode with nonzero count emits exactly that many pulses, then stops.
// - Pulse count zero means continuous pulses until recording stops.
// - First pulse or waveform starts only after the programmed delay elapses.
// - Pulse period is width plus off-time; amplitude during width, baseline during off.
// - All pulses carry the programmed amplitude unless the host rewrites it.
// - Train mode repeats a burst of count pulses for the train count, then stops.
// - Inter-train gap sits between last pulse of one train and next train.
// - Constant mode uses only amplitude, delay and holding level; other parameters ignored.
// - Constant mode drives amplitude after delay until recording stops, then rests.
// - Step level is previous level plus (stop minus start) divided by step count.
// - Each step lasts step width; nonzero off-time returns to baseline between steps.
// - Step pass repeats the repeat count with interprotocol gap between passes.
// - After a step pass output settles at holding level; next pass starts again from start amplitude.
// - Ramp and triangle hold delay amplitude for the whole delay period.
// - Each rising slope goes from start to stop amplitude over exactly the rise time.
// - Ramp mode makes the ramp count, holding level during gaps between ramps.
// - Triangle mode makes the triangle count, each from start, gaps between.
// - Tick selectable among three resolutions; all durations counted in ticks.
package sws_pkg;

	// byte addresses of the registers
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DELAY  = 8'h04;
	localparam logic [7:0] ADDR_AMP    = 8'h08;
	localparam logic [7:0] ADDR_DAMP   = 8'h0C;
	localparam logic [7:0] ADDR_HOLD   = 8'h10;
	localparam logic [7:0] ADDR_STOP   = 8'h14;
	localparam logic [7:0] ADDR_COUNT  = 8'h18;
	localparam logic [7:0] ADDR_WIDTH  = 8'h1C;
	localparam logic [7:0] ADDR_OFF    = 8'h20;
	localparam logic [7:0] ADDR_REPEAT = 8'h24;
	localparam logic [7:0] ADDR_GAP    = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2C;

	// control field positions
	localparam int CTRL_REC_BIT = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_RES_LO  = 4;

	// mode codes
	localparam logic [2:0] MODE_PULSE = 3'h0;
	localparam logic [2:0] MODE_TRAIN = 3'h1;
	localparam logic [2:0] MODE_CONST = 3'h2;
	localparam logic [2:0] MODE_STEP  = 3'h3;
	localparam logic [2:0] MODE_RAMP  = 3'h4;
	localparam logic [2:0] MODE_TRI   = 3'h5;

	// tick resolutions in ns and the clock period
	localparam int CLK_PERIOD_NS = 5;
	localparam int RES0_NS       = 40000;
	localparam int RES1_NS       = 400000;
	localparam int RES2_NS       = 4000000;
	localparam int TICK0_CYC     = RES0_NS / CLK_PERIOD_NS;
	localparam int TICK1_CYC     = RES1_NS / CLK_PERIOD_NS;
	localparam int TICK2_CYC     = RES2_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_ON, ST_OFF, ST_GAP, ST_DONE} sws_state_t;

	// protocol parameters as programmed by software
	typedef struct packed {
		logic               rec;
		logic [2:0]         mode;
		logic [1:0]         res;
		logic [15:0]        delay;
		logic signed [15:0] amp;
		logic signed [15:0] damp;
		logic signed [15:0] hold;
		logic signed [15:0] stop;
		logic [15:0]        count;
		logic [15:0]        width;
		logic [15:0]        off;
		logic [15:0]        repeats;
		logic [15:0]        gap;
	} sws_cfg_t;

	localparam sws_cfg_t CFG_RESET = '0;

endpackage

// ---- tb/sws_dac_model.sv ----
// dac and analog output stage model: follows the code and counts activity
module sws_dac_model
	import sws_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          rst_i,
	input  wire logic [15:0]   code_i,
	input  wire logic [15:0]   rest_i,
	input  wire logic          clr_i,
	output logic      [15:0]   level_o,
	output logic      [15:0]   n_on_o,
	output logic      [15:0]   cyc_on_o,
	output logic      [15:0]   first_o,
	output logic signed [15:0] peak_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic on_r;
	logic got_r;
	logic act;
	// activity means away from the programmed resting level
	assign act = (code_i !== rest_i);
	// stage settles one cycle after the code; counters restart on clear
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			level_o  <= 16'h0000;
			n_on_o   <= 16'h0000;
			cyc_on_o <= 16'h0000;
			first_o  <= 16'h0000;
			peak_o   <= 16'sh8000;
			on_r     <= 1'b0;
			got_r    <= 1'b0;
		end else if (clr_i) begin
			level_o  <= 16'h0000;
			n_on_o   <= 16'h0000;
			cyc_on_o <= 16'h0000;
			first_o  <= 16'h0000;
			peak_o   <= 16'sh8000;
			on_r     <= 1'b0;
			got_r    <= 1'b0;
		end else begin
			level_o <= code_i;
			on_r    <= act;
			if (act && !on_r)
				n_on_o <= n_on_o + 16'h0001;
			if (act)
				cyc_on_o <= cyc_on_o + 16'h0001;
			if (act)
				got_r <= 1'b1;
			if (!act && !got_r)
				first_o <= first_o + 16'h0001;
			if (act && $signed(code_i) > peak_o)
				peak_o <= $signed(code_i);
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the stimulus sequencer with the dac stage model
module tb_top
	import sws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i, rst_i, wr_i, rd_i, clr;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [15:0] dac_code_o, rest, level, n_on, cyc_on, first;
	logic signed [15:0] peak;
	int err_count, tests_run;
	sws_seq #(.TICK0(4), .TICK1(6), .TICK2(8)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dac_code_o(dac_code_o));
	sws_dac_model u_dac (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .code_i(dac_code_o), .rest_i(rest), .clr_i(clr),
		.level_o(level), .n_on_o(n_on), .cyc_on_o(cyc_on), .first_o(first), .peak_o(peak));
	// clock of 5 ns
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		clr <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 chk("rdata", rdata_o, exp);
		@(posedge clk_sys_i);
	endtask
	// program all parameters, then raise record with the model counters cleared
	task automatic go(input logic [2:0] m, input logic [1:0] r, input logic [15:0] amp, damp, hold, stp,
		cnt, wid, off, rep, gap, dly);
		wr(ADDR_AMP, {16'h0000, amp});
		wr(ADDR_DAMP, {16'h0000, damp});
		wr(ADDR_HOLD, {16'h0000, hold});
		rest <= hold;
		wr(ADDR_STOP, {16'h0000, stp});
		wr(ADDR_COUNT, {16'h0000, cnt});
		wr(ADDR_WIDTH, {16'h0000, wid});
		wr(ADDR_OFF, {16'h0000, off});
		wr(ADDR_REPEAT, {16'h0000, rep});
		wr(ADDR_GAP, {16'h0000, gap});
		wr(ADDR_DELAY, {16'h0000, dly});
		clr <= 1'b1;
		wr(ADDR_CTRL, {26'h0, r, m, 1'b1});
	endtask
	// drop record, output must return to rest
	task automatic halt();
		wr(ADDR_CTRL, 32'h0000_0000);
		cyc(2);
		chk("rest", dac_code_o, rest);
	endtask
	task automatic t_regs();
		wr(ADDR_AMP, 32'hFFFF_1234);
		wr(ADDR_GAP, 32'h0000_00A5);
		rd(ADDR_AMP, 32'h0000_1234);
		rd(ADDR_GAP, 32'h0000_00A5);
		rd(8'h30, 32'h0000_0000);
		rd(ADDR_STATUS, 32'h0000_0000);
	endtask
	task automatic t_pulse();
		int t;
		for (int r = 0; r < 3; r++) begin
			t = 4 + 2 * r;
			go(MODE_PULSE, r[1:0], 16'h0100, 16'h0000, 16'h0010, 16'h0000, 16'h0002, 16'h0002, 16'h0001,
				16'h0000, 16'h0000, 16'h0002);
			cyc(12 * t);
			chk("pulses", n_on, 16'h0002);
			chk("on_time", cyc_on, 16'(4 * t));
			chk("delay", 32'(first >= 16'(2 * t - 2) && first <= 16'(2 * t + 3)), 32'h1);
			chk("amp", peak, 16'h0100);
			halt();
		end
	endtask
	task automatic t_cont();
		go(MODE_PULSE, 2'h0, 16'h0100, 16'h0000, 16'h0010, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
			16'h0000, 16'h0000, 16'h0001);
		cyc(120);
		chk("continuous", 32'(n_on >= 16'h000C), 32'h1);
		halt();
		rd(ADDR_STATUS, 32'h0000_0000);
	endtask
	task automatic t_train();
		go(MODE_TRAIN, 2'h0, 16'h0300, 16'h0000, 16'h0010, 16'h0000, 16'h0002, 16'h0001, 16'h0001,
			16'h0003, 16'h0002, 16'h0001);
		cyc(80);
		chk("train_pulses", n_on, 16'h0006);
		chk("train_on", cyc_on, 16'h0018);
		halt();
	endtask
	task automatic t_const();
		go(MODE_CONST, 2'h0, 16'h0222, 16'h0000, 16'h0010, 16'h0000, 16'h0005, 16'h0003, 16'h0003,
			16'h0002, 16'h0002, 16'h0002);
		cyc(60);
		chk("const", dac_code_o, 16'h0222);
		chk("const_level", level, 16'h0222);
		chk("const_on", n_on, 16'h0001);
		halt();
	endtask
	// contiguous steps, or returns to baseline between steps when off is nonzero
	task automatic t_step(input logic [15:0] off, input logic [15:0] on_exp);
		go(MODE_STEP, 2'h0, 16'h0000, 16'h0000, 16'h0100, 16'h0040, 16'h0004, 16'h0001, off,
			16'h0002, 16'h0001, 16'h0001);
		cyc(80);
		chk("step_top", peak, 16'h0030);
		chk("step_on", cyc_on, 16'h0020);
		chk("passes", n_on, on_exp);
		chk("step_end", dac_code_o, 16'h0100);
		halt();
	endtask
	task automatic t_slope(input logic [2:0] m, input logic [15:0] on_exp);
		go(m, 2'h0, 16'h0000, 16'hFFE0, 16'h0100, 16'h0040, 16'h0000, 16'h0004, 16'h0000,
			16'h0002, 16'h0002, 16'h0003);
		cyc(8);
		chk("delay_amp", dac_code_o, 16'hFFE0);
		cyc(120);
		chk("slope_top", peak, 16'h0040);
		chk("slopes", n_on, 16'h0002);
		chk("slope_on", cyc_on, on_exp);
		chk("slope_end", dac_code_o, 16'h0100);
		halt();
	endtask
	// reset, then every scenario in turn
	initial begin
		err_count = 0;
		tests_run = 0;
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		clr = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		rest = 16'h0000;
		cyc(16);
		rst_i <= 1'b0;
		cyc(1);
		chk("reset_dac", dac_code_o, 16'h0000);
		t_regs();
		t_pulse();
		t_cont();
		t_train();
		t_const();
		t_step(16'h0000, 16'h0002);
		t_step(16'h0001, 16'h0008);
		t_slope(MODE_RAMP, 16'h002C);
		t_slope(MODE_TRI, 16'h004C);
		final_report();
	end
	// watchdog well beyond the expected run
	initial begin
		#100us;
		err_count++;
		final_report();
	end
endmodule
